// file: rtl/skt_top.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// (R1) exception true forces jump to configured step
// (R2) jump only when current step is interruptible
// (R3) exception drives output async set/clear or d
// (R4) kick delayed copy held in tick-clocked node
// (R5) kick exception fires only on falling edge
// (R6) edge is kick low, copy high, one tick
// (R7) gated timer counts delay down, then terminal
// (R8) gate low reloads delay, restarts countdown
// (R9) inverted terminal on gate gives pulse train
// (R10) timer one gate registers inverse of terminal
// (R11) nodes: combinatorial, d, t, preset, reset
// (R12) supervisory logic runs independent of sequencer
// (R13) three internal bits count timer one pulses
// (R14) t flops toggle on terminal with lower bits
// (R15) long output pulses one tick per interval
// (R16) long output clears all three counter bits
// (R17) long output set at fifth terminal pulse
module skt_top
	import skt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic kick_in,
	input wire logic step_interruptible,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic jump_req,
	output logic [STEP_W-1:0] jump_step,
	output logic exc_out,
	output logic long_interval_out,
	output logic irq
);
	// sequencer tick generator
	logic [TICK_W-1:0] div_q; // mclk cycles into the current tick
	logic tick_q; // one mclk pulse every four microseconds
	logic tick_end;
	assign tick_end = div_q == TICK_W'(TICK_CYC - 1);

	// register file state
	logic gate0_q; // software gate of timer zero
	logic [DLY_W-1:0] dly_q [NTMR]; // programmed delays in ticks
	logic [7:0] exc_cfg_q; // target step and slot zero action
	logic [NIRQ-1:0] istat_q; // sticky event bits
	logic [NIRQ-1:0] imask_q; // event enables
	logic [31:0] rdata_q;
	logic irq_q;

	// exception and supervisory state
	logic kick_copy; // delayed copy of the kick, slot one node
	logic kick_fall; // falling edge condition of the kick
	logic exc0_hit; // slot zero became true this tick
	logic exc0_node;
	logic jump_q;
	logic [STEP_W-1:0] jstep_q;
	logic gate1_q; // registered gate of timer one
	logic [NTMR-1:0] tc_w; // terminal counts of both timers
	logic [NTMR-1:0] gate_w;
	logic [2:0] ivl_q; // interval counter bits msb..lsb
	logic [2:0] ivl_t; // toggle enables of those bits
	logic long_q;
	logic tc0_prev_q; // for the rising edge of timer zero

	// slot one latches the kick; always follows, so no config here
	skt_exc_slot u_kick_latch (
		.mclk(mclk),
		.rst(rst),
		.tick(tick_q),
		.expr(kick_in),
		.mode(SKT_ACT_FOLLOW), // R4
		.hit(),
		.node(kick_copy)
	);

	// kick low while the copy is still high lasts at most one tick,
	// so a kick stuck low cannot keep re-arming the jump
	assign kick_fall = !kick_in && kick_copy; // R5 R6

	// slot zero watches the falling edge and drives the exception output
	skt_exc_slot u_kick_exc (
		.mclk(mclk),
		.rst(rst),
		.tick(tick_q),
		.expr(kick_fall),
		.mode(skt_act_type'(exc_cfg_q[F_MODE_LO+1:F_MODE_LO])),
		.hit(exc0_hit),
		.node(exc0_node)
	);

	// timer gates: zero from software, one self-retriggering
	assign gate_w[0] = gate0_q;
	assign gate_w[1] = gate1_q;

	// both hardware timers from one loop
	genvar gi;
	generate
		for (gi = 0; gi < NTMR; gi++) begin : g_tmr
			skt_countdown u_tmr (
				.mclk(mclk),
				.rst(rst),
				.tick(tick_q),
				.gate(gate_w[gi]),
				.delay(dly_q[gi]),
				.tc(tc_w[gi])
			);
		end
	endgenerate

	// tick divider, free running so supervisory logic never waits
	always_ff @(posedge mclk or posedge rst) begin // R12
		if (rst) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= tick_end ? '0 : div_q + TICK_W'(1);
			tick_q <= tick_end;
		end
	end

	// jump request: only honoured on an interruptible step
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			jump_q <= 1'b0;
			jstep_q <= '0;
		end else begin
			jump_q <= exc0_hit && step_interruptible; // R1 R2
			if (exc0_hit && step_interruptible) begin
				jstep_q <= exc_cfg_q[STEP_W-1:0]; // R1
			end
		end
	end

	// timer one gate is a d flop of its inverted terminal count,
	// giving one-tick pulses every programmed delay plus two ticks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gate1_q <= 1'b0;
		end else if (tick_q) begin
			gate1_q <= !tc_w[1]; // R9 R10
		end
	end

	// t flop enables: each bit toggles when all lower bits are set
	assign ivl_t[0] = tc_w[1]; // R14
	assign ivl_t[1] = tc_w[1] && ivl_q[0]; // R14
	assign ivl_t[2] = tc_w[1] && ivl_q[0] && ivl_q[1]; // R14

	// interval counter: internal t flops, never driven to pins.
	// the clear from the long output is held through the next tick and wins over its count,
	// but timer one is never terminal on that tick, so no count is ever lost to it
	always_ff @(posedge mclk or posedge rst) begin // R11 R13
		if (rst) begin
			ivl_q <= '0;
		end else if (long_q) begin
			ivl_q <= '0; // R16
		end else if (tick_q) begin
			ivl_q <= ivl_q ^ ivl_t; // R14
		end
	end

	// long output: d flop set on the fifth pulse, one tick wide
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			long_q <= 1'b0;
		end else if (tick_q) begin
			long_q <= tc_w[1] && ivl_q == IVL_LAST; // R15 R17
		end
	end

	// register decode
	logic wr_ctrl, wr_dly0, wr_dly1, wr_exc, wr_istat, wr_imask;
	assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
	assign wr_dly0 = reg_wr && reg_addr == A_DLY0;
	assign wr_dly1 = reg_wr && reg_addr == A_DLY1;
	assign wr_exc = reg_wr && reg_addr == A_EXC;
	assign wr_istat = reg_wr && reg_addr == A_ISTAT;
	assign wr_imask = reg_wr && reg_addr == A_IMASK;

	// delay written is clamped into the legal 32 us .. 2 s window
	logic [DLY_W-1:0] dly_wr;
	logic [31:0] wd;
	assign wd = reg_wdata;
	assign dly_wr = (wd < 32'(DLY_MIN)) ? DLY_MIN :
		(wd > 32'(DLY_MAX)) ? DLY_MAX : wd[DLY_W-1:0];

	// control and configuration registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gate0_q <= 1'b0;
			dly_q[0] <= DLY_MAX;
			dly_q[1] <= DLY_MAX;
			exc_cfg_q <= R_EXC;
			imask_q <= R_MASK;
		end else begin
			if (wr_ctrl) gate0_q <= reg_wdata[F_GATE0];
			if (wr_dly0) dly_q[0] <= dly_wr;
			if (wr_dly1) dly_q[1] <= dly_wr;
			if (wr_exc) exc_cfg_q <= reg_wdata[7:0];
			if (wr_imask) imask_q <= reg_wdata[NIRQ-1:0];
		end
	end

	// event sources for the sticky status
	logic [NIRQ-1:0] ev_w;
	logic [NIRQ-1:0] clr_w;
	assign ev_w[I_KICK] = exc0_hit;
	assign ev_w[I_JUMP] = exc0_hit && step_interruptible;
	assign ev_w[I_LONG] = tick_q && tc_w[1] && ivl_q == IVL_LAST;
	assign ev_w[I_TC0] = tc_w[0] && !tc0_prev_q;
	assign clr_w = wr_istat ? reg_wdata[NIRQ-1:0] : '0;

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			istat_q <= '0;
			tc0_prev_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			istat_q <= (istat_q & ~clr_w) | ev_w;
			tc0_prev_q <= tc_w[0];
			irq_q <= |(((istat_q & ~clr_w) | ev_w) & imask_q);
		end
	end

	// read mux; unmapped addresses read as zero
	logic [31:0] rd_mux;
	logic [31:0] stat_w;
	assign stat_w = {24'h0, exc0_node, ivl_q, gate1_q, tc_w, kick_copy};
	assign rd_mux =
		(reg_addr == A_CTRL) ? {31'h0, gate0_q} :
		(reg_addr == A_DLY0) ? {13'h0, dly_q[0]} :
		(reg_addr == A_DLY1) ? {13'h0, dly_q[1]} :
		(reg_addr == A_EXC) ? {24'h0, exc_cfg_q} :
		(reg_addr == A_STAT) ? stat_w :
		(reg_addr == A_ISTAT) ? {28'h0, istat_q} :
		(reg_addr == A_IMASK) ? {28'h0, imask_q} : 32'h0;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// output exception action through its own flop
	logic exc_out_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			exc_out_q <= 1'b0;
		end else begin
			exc_out_q <= exc0_node; // R3
		end
	end

	assign reg_rdata = rdata_q;
	assign jump_req = jump_q;
	assign jump_step = jstep_q;
	assign exc_out = exc_out_q;
	assign long_interval_out = long_q;
	assign irq = irq_q;

	// checks
	a_jump_gated: assert property (@(posedge mclk) disable iff (rst) // R2
		jump_q |-> $past(step_interruptible) && $past(exc0_hit))
		else $error("jump issued on a non-interruptible step");
	a_jump_target: assert property (@(posedge mclk) disable iff (rst) // R1
		exc0_hit && step_interruptible |=> jump_q &&
			jstep_q == $past(exc_cfg_q[STEP_W-1:0]))
		else $error("jump missing or to the wrong step");
	a_kick_copy: assert property (@(posedge mclk) disable iff (rst) // R4
		tick_q |=> kick_copy == $past(kick_in))
		else $error("kick copy not updated on the tick");
	a_edge_single: assert property (@(posedge mclk) disable iff (rst) // R5
		exc0_hit |=> !exc0_hit [*8])
		else $error("kick exception fired twice for one edge");
	a_edge_needs_fall: assert property (@(posedge mclk) disable iff (rst) // R6
		exc0_hit |-> $past(!kick_in && kick_copy))
		else $error("kick exception without a falling edge");
	a_gate1_inverse: assert property (@(posedge mclk) disable iff (rst) // R10
		tick_q |=> gate1_q == !$past(tc_w[1]))
		else $error("timer one gate is not the inverted terminal");
	a_lsb_toggle: assert property (@(posedge mclk) disable iff (rst) // R14
		tick_q && tc_w[1] && !long_q |=> ivl_q[0] != $past(ivl_q[0]))
		else $error("interval lsb did not toggle");
	a_long_clear: assert property (@(posedge mclk) disable iff (rst) // R16
		long_q |=> ivl_q == 3'h0)
		else $error("long output did not clear the counter");
	a_long_decode: assert property (@(posedge mclk) disable iff (rst) // R17
		tick_q && tc_w[1] && ivl_q == IVL_LAST |=> long_q)
		else $error("long output not set on the fifth pulse");
	a_tc_one_tick: assert property (@(posedge mclk) disable iff (rst) // R9
		tick_q && tc_w[1] |=> !tc_w[1])
		else $error("timer one terminal wider than one tick");
endmodule

// file: common/skt_pkg.sv
// shared constants for the sequencer timer and kick edge block
package skt_pkg;
	// clocking: fast system clock and the slow sequencer tick
	localparam int MCLK_NS = 8;
	localparam int TICK_NS = 4000;
	localparam int TICK_CYC = TICK_NS / MCLK_NS;
	localparam int TICK_W = 9;
	// countdown delay limits, in microseconds and in ticks
	localparam int DLY_MIN_US = 32;
	localparam int DLY_MAX_US = 2000000;
	localparam int TICK_US = TICK_NS / 1000;
	localparam int DLY_W = 19;
	localparam logic [DLY_W-1:0] DLY_MIN = DLY_W'((DLY_MIN_US + TICK_US - 1) / TICK_US);
	localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(DLY_MAX_US / TICK_US);
	// number of hardware countdown timers
	localparam int NTMR = 2;
	// sequencer step number width
	localparam int STEP_W = 5;
	// interval counter decode: fifth pulse seen while count holds four
	localparam logic [2:0] IVL_LAST = 3'h4;
	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DLY0 = 8'h04;
	localparam logic [7:0] A_DLY1 = 8'h08;
	localparam logic [7:0] A_EXC = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_ISTAT = 8'h14;
	localparam logic [7:0] A_IMASK = 8'h18;
	// field positions
	localparam int F_GATE0 = 0;
	localparam int F_MODE_LO = 5;
	localparam int NIRQ = 4;
	localparam int I_KICK = 0;
	localparam int I_JUMP = 1;
	localparam int I_LONG = 2;
	localparam int I_TC0 = 3;
	// reset values
	localparam logic [7:0] R_EXC = 8'h00;
	localparam logic [NIRQ-1:0] R_MASK = 4'h0;
	// output action of an exception slot
	typedef enum logic [1:0] {
		SKT_ACT_NONE,
		SKT_ACT_SET,
		SKT_ACT_CLR,
		SKT_ACT_FOLLOW
	} skt_act_type;
endpackage

// file: rtl/skt_countdown.sv
`timescale 1ns/1ps
// one gated countdown timer clocked by the sequencer tick
module skt_countdown
	import skt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic gate,
	input wire logic [DLY_W-1:0] delay,
	output logic tc
);
	logic [DLY_W-1:0] cnt_q; // remaining ticks
	logic [DLY_W-1:0] cnt_d;
	logic loaded_q; // a delay has been loaded since reset
	// terminal count is a decode, so it drops the tick the gate drops;
	// the zero left by reset is not a finished count, so it never fires
	assign tc = gate && loaded_q && (cnt_q == '0); // R7
	// gate low reloads, gate high counts down and parks at zero;
	// the first tick after reset always loads, whatever the gate
	assign cnt_d = (!gate || !loaded_q) ? delay : // R8
		(cnt_q != '0) ? cnt_q - DLY_W'(1) : cnt_q; // R7
	// counter only moves on the tick
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			loaded_q <= 1'b0;
		end else if (tick) begin
			cnt_q <= cnt_d;
			loaded_q <= 1'b1;
		end
	end
	a_gate_reload: assert property (@(posedge mclk) disable iff (rst) // R8
		tick && !gate |=> cnt_q == $past(delay))
		else $error("timer did not reload while gate low");
	a_count_step: assert property (@(posedge mclk) disable iff (rst) // R7
		tick && gate && cnt_q != '0 |=> cnt_q == $past(cnt_q) - DLY_W'(1))
		else $error("timer did not count down by one");
endmodule

// file: rtl/skt_exc_slot.sv
`timescale 1ns/1ps
// one exception slot: hit on a rising expression, plus an output action
module skt_exc_slot
	import skt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic tick,
	input wire logic expr,
	input wire skt_act_type mode,
	output logic hit,
	output logic node
);
	logic prev_q; // expression at the previous tick
	logic hit_q; // one mclk pulse when expression becomes true
	logic node_q; // controlled output flip-flop
	logic rise_w;
	assign rise_w = tick && expr && !prev_q; // R1
	// edge of the expression is judged only at tick boundaries
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
			hit_q <= 1'b0;
		end else begin
			hit_q <= rise_w;
			if (tick) begin
				prev_q <= expr;
			end
		end
	end
	// set and clear act at once, follow waits for the tick like a d flop
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			node_q <= 1'b0;
		end else begin
			case (mode)
				SKT_ACT_SET: if (expr) node_q <= 1'b1; // R3
				SKT_ACT_CLR: if (expr) node_q <= 1'b0; // R3
				SKT_ACT_FOLLOW: if (tick) node_q <= expr; // R3
				default: node_q <= node_q;
			endcase
		end
	end
	assign hit = hit_q;
	assign node = node_q;
	a_set_action: assert property (@(posedge mclk) disable iff (rst) // R3
		mode == SKT_ACT_SET && expr |=> node_q)
		else $error("set action did not set the output");
endmodule

// file: dv/skt_kick_host.sv
`timescale 1ns/1ps
// host processor side of the kick line: strokes the watchdog on command
module skt_kick_host
	import skt_pkg::*;
(
	input wire logic mclk,
	output logic kick_in
);
	// idle high, so only a stroke can make a falling edge
	initial kick_in = 1'b1;

	// one stroke: low for lo ticks, then high for two ticks
	// both levels last whole ticks, else the tick sampler could miss one
	task automatic pulse(input int lo);
		@(posedge mclk);
		kick_in <= 1'b0;
		repeat (lo * TICK_CYC) @(posedge mclk);
		kick_in <= 1'b1;
		repeat (2 * TICK_CYC) @(posedge mclk);
	endtask
endmodule

// file: dv/skt_top_test.sv
`timescale 1ns/1ps
// self-checking bench: register bus, kick exceptions, timers, long interval
module skt_top_test;
	import skt_pkg::*;
	// read expectation: value under a mask of the bits that matter
	typedef struct {
		logic [31:0] v;
		logic [31:0] m;
	} skt_rexp_type;
	// timer one delay in ticks, kept at the minimum to shorten the run
	localparam logic [31:0] D1 = 32'h8;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic kick_in;
	logic step_interruptible = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic jump_req;
	logic [STEP_W-1:0] jump_step;
	logic exc_out;
	logic long_interval_out;
	logic irq;
	int n_mismatch = 0;
	int num_checks = 0;
	skt_rexp_type rq[$]; // pending read expectations
	logic [STEP_W-1:0] jq[$]; // pending jump targets
	skt_rexp_type e;
	logic rd_q = 1'b0; // a read was taken at the last edge
	logic long_q = 1'b0;
	logic exc_q = 1'b0;
	int cyc = 0;
	int t_rise = 0;
	int n_long = 0;
	int n_exc = 0; // rises of the exception output
	logic [STEP_W-1:0] st;
	int k;
	skt_act_type acts[3] = '{SKT_ACT_SET, SKT_ACT_CLR, SKT_ACT_FOLLOW};

	// 8 ns clock
	initial begin
		forever #4 mclk = ~mclk;
	end

	skt_kick_host host (
		.mclk(mclk),
		.kick_in(kick_in)
	);

	skt_top dut (
		.mclk(mclk),
		.rst(rst),
		.kick_in(kick_in),
		.step_interruptible(step_interruptible),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.jump_req(jump_req),
		.jump_step(jump_step),
		.exc_out(exc_out),
		.long_interval_out(long_interval_out),
		.irq(irq)
	);

	// single comparison point
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one-cycle write strobe; the gap cycle after it keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// one-cycle read strobe; the expectation is queued for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		rq.push_back('{v, m});
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask

	task automatic ticks(input int n);
		repeat (n * TICK_CYC) @(posedge mclk);
	endtask

	// result monitor: read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		rd_q <= reg_rd;
		if (rd_q) begin
			e = rq.pop_front();
			chk(reg_rdata & e.m, e.v);
		end
		if (jump_req) begin
			// a jump nobody asked for is a fault in itself
			if (jq.size() == 0) chk(32'(jump_req), 32'h0);
			else chk(32'(jump_step), 32'(jq.pop_front()));
		end
	end

	// long pulse width and spacing, rises of the exception output
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		long_q <= long_interval_out;
		exc_q <= exc_out;
		if (exc_out && !exc_q) n_exc <= n_exc + 1;
		if (long_interval_out && !long_q) begin
			// the first interval starts at reset, so only later ones are timed
			if (n_long > 0) chk(32'(cyc - t_rise), 32'(5 * (D1 + 2) * TICK_CYC));
			t_rise <= cyc;
			n_long <= n_long + 1;
		end
		if (!long_interval_out && long_q) chk(32'(cyc - t_rise), 32'(TICK_CYC));
	end

	// hang guard, well above the expected run length
	initial begin
		repeat (90000) @(posedge mclk);
		n_mismatch++;
		finish_test();
	end

	// main sequence
	initial begin
		void'($urandom(32'h25dd));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		// reset values, unmapped place, delay clamping
		rd(A_DLY1, 32'(DLY_MAX), '1);
		wr(A_DLY1, D1); // must land before the first tick reloads timer one
		rd(A_CTRL, 32'h0, '1);
		rd(A_EXC, 32'(R_EXC), '1);
		rd(A_IMASK, 32'(R_MASK), '1);
		rd(8'h1C, 32'h0, '1);
		wr(A_DLY0, 32'h0);
		rd(A_DLY0, 32'(DLY_MIN), '1);
		wr(A_DLY0, 32'hFFFFF);
		rd(A_DLY0, 32'(DLY_MAX), '1);
		// timer zero: a gate drop restarts the count, a full count fires
		wr(A_DLY0, 32'hA);
		wr(A_CTRL, 32'h1);
		ticks(6);
		wr(A_CTRL, 32'h0);
		ticks(2);
		wr(A_CTRL, 32'h1);
		ticks(6);
		rd(A_ISTAT, 32'h0, 32'h1 << I_TC0);
		ticks(8);
		rd(A_ISTAT, 32'h1 << I_TC0, 32'h1 << I_TC0);
		wr(A_CTRL, 32'h0);
		// kick exceptions in the set, clear and follow actions, random targets and widths
		for (int i = 0; i < 3; i++) begin
			st = STEP_W'($urandom);
			wr(A_EXC, 32'({acts[i], st}));
			jq.push_back(st);
			host.pulse($urandom_range(3, 1));
			ticks(1);
			chk(32'(exc_out), 32'(i == 0));
			if (i == 0) begin
				// masked event leaves irq low, unmasking raises it
				chk(32'(irq), 32'h0);
				rd(A_ISTAT, 32'h3, 32'h3);
				wr(A_IMASK, 32'h1 << I_KICK);
				repeat (2) @(posedge mclk);
				chk(32'(irq), 32'h1);
				wr(A_ISTAT, 32'h3);
				repeat (2) @(posedge mclk);
				chk(32'(irq), 32'h0);
			end
		end
		// edge seen, but the step may not be interrupted: no jump
		wr(A_ISTAT, 32'hF);
		step_interruptible <= 1'b0;
		host.pulse(2);
		rd(A_ISTAT, 32'h1, 32'h3);
		step_interruptible <= 1'b1;
		// kick held low for many ticks gives a single jump
		jq.push_back(st);
		host.pulse(6);
		// counter steps between timer one pulses, kick copy high
		k = n_long;
		while (n_long == k || long_interval_out) @(posedge mclk);
		for (int i = 1; i < 5; i++) begin
			ticks(i == 1 ? 14 : 10);
			rd(A_STAT, 32'(i << 4) | 32'h1, 32'h71);
		end
		// next long pulse clears the count
		k = n_long;
		while (n_long == k || long_interval_out) @(posedge mclk);
		rd(A_STAT, 32'h0, 32'h70);
		repeat (4) @(posedge mclk);
		chk(32'(n_exc), 32'h4);
		chk(32'(jq.size()), 32'h0);
		chk(32'(rq.size()), 32'h0);
		finish_test();
	end
endmodule
